// file: logic/ctlo_top.sv
// test-mode pin gating, loopback, error counter freeze and mailbox overrun flags
`timescale 1ns/10ps
// Notes on behaviour
// - with the freeze bit clear the two error counters follow the core's count requests.
// - with the freeze bit set in test mode both error counters hold their value.
// - with the receive-disable and loopback bits clear the pin level reaches the core.
// - receive disabled without loopback feeds a constant recessive level to the core.
// - receive disabled with loopback feeds the internal transmit stream to the core.
// - with the transmit-disable bit clear the core's bit stream drives the transmit pin.
// - transmit disabled without loopback holds the transmit pin recessive.
// - transmit disabled with loopback sends the transmit stream to the internal receive.
// - the internal receive comes from the pin unless loopback or receive disable is set in test mode.
// - the four test bits reset to zero and are readable and writable.
// - there is one overrun flag for each of four mailboxes.
// - a reception for a mailbox whose pending bit is still set raises its overrun flag.
// - writing one clears an overrun flag and writing zero leaves it alone.
// - overrun flags reset to zero and the upper status bits read as zero.
module ctlo_top
   import ctlo_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // protocol core side
   input  wire logic        core_tx_bit,
   output logic             core_rx_bit,
   input  wire logic        tec_inc,
   input  wire logic        tec_dec,
   input  wire logic        rec_inc,
   input  wire logic        rec_dec,
   output logic [8:0]       transmit_error_counter,
   output logic [8:0]       receive_error_counter,
   // mailbox reception events
   input  wire logic [3:0]  mbox_rx_event,
   input  wire logic [3:0]  receive_pending_flags,
   input  wire logic [3:0]  remote_frame_pending_flags,
   // can pins
   input  wire logic        can_receive_line,
   output logic             can_transmit_line
);

   // ***************************************************************
   // state and decode
   // ***************************************************************
   ctlo_state_t st_reg;
   ctlo_state_t st_next;
   logic        acc;
   logic        wr;
   logic        hit_ctrl;
   logic        hit_ovr;
   logic        hit_mode;
   logic        freeze_eff;
   logic        rx_dis_eff;
   logic        tx_dis_eff;
   logic        loop_eff;
   logic        pin_rx;

   // zero-wait slave: every access completes in its first access cycle
   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign hit_ctrl = paddr == CTLO_TEST_CTRL_OFF;
   assign hit_ovr  = paddr == CTLO_OVR_STATUS_OFF;
   assign hit_mode = paddr == CTLO_TEST_MODE_OFF;
   assign pready   = 1'b1;
   assign pslverr  = acc & ~(hit_ctrl | hit_ovr | hit_mode);
   assign prdata   = st_reg.prdata;

   // test bits only count while test mode is set
   assign freeze_eff = st_reg.test_mode & st_reg.test_ctrl[CTLO_ERR_FREEZE_BIT];
   assign rx_dis_eff = st_reg.test_mode & st_reg.test_ctrl[CTLO_RX_DIS_BIT];
   assign tx_dis_eff = st_reg.test_mode & st_reg.test_ctrl[CTLO_TX_DIS_BIT];
   assign loop_eff   = st_reg.test_mode & st_reg.test_ctrl[CTLO_LOOP_BIT];
   assign pin_rx     = st_reg.rx_sync[1];

   // ***************************************************************
   // pin paths
   // ***************************************************************
   // combinational so a bit is not delayed on the bus; loop applies when either
   // disable is set, and loop alone also feeds the transmit stream back
   always_comb begin
      if (loop_eff) begin
         core_rx_bit = core_tx_bit;
      end else if (rx_dis_eff) begin
         core_rx_bit = CTLO_RECESSIVE;
      end else begin
         core_rx_bit = pin_rx;
      end
      if (tx_dis_eff) begin
         can_transmit_line = CTLO_RECESSIVE;
      end else begin
         can_transmit_line = core_tx_bit;
      end
   end

   assign transmit_error_counter = st_reg.tx_err_cnt;
   assign receive_error_counter  = st_reg.rx_err_cnt;

   // ***************************************************************
   // next state
   // ***************************************************************
   // overrun set wins over a same-cycle write-one clear
   always_comb begin
      st_next         = st_reg;
      st_next.rx_sync = {st_reg.rx_sync[0], can_receive_line};
      if (wr && hit_ctrl) begin
         st_next.test_ctrl = pwdata[3:0];
      end
      if (wr && hit_mode) begin
         st_next.test_mode = pwdata[0];
      end
      if (wr && hit_ovr) begin
         st_next.ovr_flags = st_reg.ovr_flags & ~pwdata[3:0];
      end
      st_next.ovr_flags = st_next.ovr_flags
                        | (mbox_rx_event & (receive_pending_flags
                                           | remote_frame_pending_flags));
      if (!freeze_eff) begin
         // saturating counters, the core asks for the standard's steps
         if (tec_inc && st_reg.tx_err_cnt != 9'h1ff) begin
            st_next.tx_err_cnt = st_reg.tx_err_cnt + 9'h001;
         end else if (tec_dec && st_reg.tx_err_cnt != 9'h000) begin
            st_next.tx_err_cnt = st_reg.tx_err_cnt - 9'h001;
         end
         if (rec_inc && st_reg.rx_err_cnt != 9'h1ff) begin
            st_next.rx_err_cnt = st_reg.rx_err_cnt + 9'h001;
         end else if (rec_dec && st_reg.rx_err_cnt != 9'h000) begin
            st_next.rx_err_cnt = st_reg.rx_err_cnt - 9'h001;
         end
      end
      // read data registered in the setup cycle
      st_next.prdata = 32'h0000_0000;
      // hold the word through the access cycle, so the master's sampling edge
      // still sees it and never races the return to zero
      if (acc && !pwrite) begin
         st_next.prdata = st_reg.prdata;
      end
      if (psel && !penable && !pwrite) begin
         if (hit_ctrl) begin
            st_next.prdata = {28'h000_0000, st_reg.test_ctrl};
         end else if (hit_ovr) begin
            st_next.prdata = {28'h000_0000, st_reg.ovr_flags};
         end else if (hit_mode) begin
            st_next.prdata = {31'h0000_0000, st_reg.test_mode};
         end
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.test_ctrl  <= CTLO_TEST_CTRL_RST;
         st_reg.ovr_flags  <= CTLO_OVR_STATUS_RST;
         st_reg.test_mode  <= CTLO_TEST_MODE_RST;
         st_reg.tx_err_cnt <= CTLO_ERR_CNT_RST;
         st_reg.rx_err_cnt <= CTLO_ERR_CNT_RST;
         st_reg.rx_sync    <= 2'h3;
         st_reg.prdata     <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   sequence s_ovr_cause(int i);
      mbox_rx_event[i] && (receive_pending_flags[i] || remote_frame_pending_flags[i]);
   endsequence

   a_ovr_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(0) |=> st_reg.ovr_flags[0])
      else $error("overrun flag 0 not set");
   a_ovr_flag_clr: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_ovr && pwdata[1] && !mbox_rx_event[1]) |=> !st_reg.ovr_flags[1])
      else $error("overrun flag 1 not cleared");
   a_ovr_zero_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_ovr && !pwdata[2] && st_reg.ovr_flags[2]) |=> st_reg.ovr_flags[2])
      else $error("zero write cleared flag");
   a_ovr_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_ovr) |=> prdata[31:4] == 28'h000_0000)
      else $error("upper status bits not zero");
   a_err_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      freeze_eff |=> $stable(transmit_error_counter) && $stable(receive_error_counter))
      else $error("counter moved while frozen");
   a_err_count: assert property (@(posedge pclk) disable iff (!presetn)
      (!freeze_eff && tec_inc && transmit_error_counter != 9'h1ff)
      |=> transmit_error_counter == $past(transmit_error_counter) + 9'h001)
      else $error("tec did not count");
   a_rx_recessive: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_dis_eff && !loop_eff) |-> core_rx_bit == CTLO_RECESSIVE)
      else $error("rx not recessive");
   a_loop_path: assert property (@(posedge pclk) disable iff (!presetn)
      loop_eff |-> core_rx_bit == core_tx_bit)
      else $error("loopback broken");
   a_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
      tx_dis_eff |-> can_transmit_line == CTLO_RECESSIVE)
      else $error("tx pin not recessive");
   a_normal_mode: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.test_mode |-> can_transmit_line == core_tx_bit && core_rx_bit == pin_rx)
      else $error("test bits active outside test mode");
   a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_ctrl) |=> st_reg.test_ctrl == $past(pwdata[3:0]))
      else $error("test control not written");

   // ***************************************************************
   // overrun flag assertions, one set per mailbox
   // ***************************************************************
   // write-one clear of a flag with no reception in the same cycle
   sequence s_ovr_wclr(int i);
      wr && hit_ovr && pwdata[i] && !mbox_rx_event[i];
   endsequence
   // write of zero over a flag that stands
   sequence s_ovr_wkeep(int i);
      wr && hit_ovr && !pwdata[i] && st_reg.ovr_flags[i];
   endsequence

   // a reception onto a pending mailbox raises its flag
   a_ovr_set_one: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(1) |=> st_reg.ovr_flags[1])
      else $error("overrun flag 1 not set");
   a_ovr_set_two: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(2) |=> st_reg.ovr_flags[2])
      else $error("overrun flag 2 not set");
   a_ovr_set_three: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(3) |=> st_reg.ovr_flags[3])
      else $error("overrun flag 3 not set");

   // writing one clears the flag
   a_ovr_clr_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_wclr(0) |=> !st_reg.ovr_flags[0])
      else $error("overrun flag 0 not cleared");
   a_ovr_clr_two: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_wclr(2) |=> !st_reg.ovr_flags[2])
      else $error("overrun flag 2 not cleared");
   a_ovr_clr_three: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_wclr(3) |=> !st_reg.ovr_flags[3])
      else $error("overrun flag 3 not cleared");

   // writing zero leaves the flag alone
   a_ovr_keep_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_wkeep(0) |=> st_reg.ovr_flags[0])
      else $error("zero write cleared flag 0");
   a_ovr_keep_one: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_wkeep(1) |=> st_reg.ovr_flags[1])
      else $error("zero write cleared flag 1");
   a_ovr_keep_three: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_wkeep(3) |=> st_reg.ovr_flags[3])
      else $error("zero write cleared flag 3");

   // a set flag stays until software clears it
   a_ovr_stay_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.ovr_flags[0] && !(wr && hit_ovr)) |=> st_reg.ovr_flags[0])
      else $error("overrun flag 0 dropped");
   a_ovr_stay_one: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.ovr_flags[1] && !(wr && hit_ovr)) |=> st_reg.ovr_flags[1])
      else $error("overrun flag 1 dropped");
   a_ovr_stay_two: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.ovr_flags[2] && !(wr && hit_ovr)) |=> st_reg.ovr_flags[2])
      else $error("overrun flag 2 dropped");
   a_ovr_stay_three: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.ovr_flags[3] && !(wr && hit_ovr)) |=> st_reg.ovr_flags[3])
      else $error("overrun flag 3 dropped");

   // no reception, no flag
   a_ovr_quiet_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_reg.ovr_flags[0] && !mbox_rx_event[0]) |=> !st_reg.ovr_flags[0])
      else $error("overrun flag 0 set without cause");
   a_ovr_quiet_one: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_reg.ovr_flags[1] && !mbox_rx_event[1]) |=> !st_reg.ovr_flags[1])
      else $error("overrun flag 1 set without cause");
   a_ovr_quiet_two: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_reg.ovr_flags[2] && !mbox_rx_event[2]) |=> !st_reg.ovr_flags[2])
      else $error("overrun flag 2 set without cause");
   a_ovr_quiet_three: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_reg.ovr_flags[3] && !mbox_rx_event[3]) |=> !st_reg.ovr_flags[3])
      else $error("overrun flag 3 set without cause");

   // a reception in the clearing cycle must not be lost
   a_ovr_wins_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(0) ##0 (wr && hit_ovr && pwdata[0]) |=> st_reg.ovr_flags[0])
      else $error("clear beat set on flag 0");
   a_ovr_wins_one: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(1) ##0 (wr && hit_ovr && pwdata[1]) |=> st_reg.ovr_flags[1])
      else $error("clear beat set on flag 1");
   a_ovr_wins_two: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(2) ##0 (wr && hit_ovr && pwdata[2]) |=> st_reg.ovr_flags[2])
      else $error("clear beat set on flag 2");
   a_ovr_wins_three: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovr_cause(3) ##0 (wr && hit_ovr && pwdata[3]) |=> st_reg.ovr_flags[3])
      else $error("clear beat set on flag 3");

   // ***************************************************************
   // read path assertions
   // ***************************************************************
   // a read setup followed by its access cycle
   sequence s_rd_access;
      (psel && !penable && !pwrite) ##1 (psel && penable && !pwrite);
   endsequence

   a_rd_stands: assert property (@(posedge pclk) disable iff (!presetn)
      s_rd_access |=> $stable(prdata))
      else $error("read data moved in access cycle");
   a_ovr_read_back: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_ovr) |=> prdata[3:0] == $past(st_reg.ovr_flags))
      else $error("overrun flags not read back");
   a_ctrl_read_back: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_ctrl)
      |=> prdata == {28'h000_0000, $past(st_reg.test_ctrl)})
      else $error("test control not read back");
   a_mode_read_back: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_mode)
      |=> prdata == {31'h0000_0000, $past(st_reg.test_mode)})
      else $error("test mode not read back");

   // ***************************************************************
   // error counter assertions
   // ***************************************************************
   a_tec_dec: assert property (@(posedge pclk) disable iff (!presetn)
      (!freeze_eff && !tec_inc && tec_dec && transmit_error_counter != 9'h000)
      |=> transmit_error_counter == $past(transmit_error_counter) - 9'h001)
      else $error("tec did not count down");
   a_rec_count: assert property (@(posedge pclk) disable iff (!presetn)
      (!freeze_eff && rec_inc && receive_error_counter != 9'h1ff)
      |=> receive_error_counter == $past(receive_error_counter) + 9'h001)
      else $error("rec did not count");
   a_rec_dec: assert property (@(posedge pclk) disable iff (!presetn)
      (!freeze_eff && !rec_inc && rec_dec && receive_error_counter != 9'h000)
      |=> receive_error_counter == $past(receive_error_counter) - 9'h001)
      else $error("rec did not count down");
   // saturation keeps a counter from wrapping to zero
   a_tec_sat: assert property (@(posedge pclk) disable iff (!presetn)
      (tec_inc && transmit_error_counter == 9'h1ff) |=> transmit_error_counter == 9'h1ff)
      else $error("tec wrapped");
   a_cnt_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (!tec_inc && !tec_dec && !rec_inc && !rec_dec)
      |=> $stable(transmit_error_counter) && $stable(receive_error_counter))
      else $error("counter moved without request");
   a_freeze_only_test: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_reg.test_mode && tec_inc && transmit_error_counter != 9'h1ff)
      |=> transmit_error_counter != $past(transmit_error_counter))
      else $error("counter frozen outside test mode");

   // ***************************************************************
   // pin path assertions
   // ***************************************************************
   a_rx_pin_path: assert property (@(posedge pclk) disable iff (!presetn)
      (!rx_dis_eff && !loop_eff) |-> core_rx_bit == pin_rx)
      else $error("pin level not passed to core");
   // the pin reaches the core two edges late, never sooner
   a_rx_sync_two: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |-> pin_rx == $past(can_receive_line, 2))
      else $error("receive synchroniser latency wrong");
   a_tx_drive: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_dis_eff |-> can_transmit_line == core_tx_bit)
      else $error("core stream not on transmit pin");
   a_loop_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_dis_eff && loop_eff)
      |-> can_transmit_line == CTLO_RECESSIVE && core_rx_bit == core_tx_bit)
      else $error("internal loop with pin gating broken");

endmodule // ctlo_top

// file: logic/ctlo_pkg.sv
// package: register map, field positions and reset values of the test-loop block
package ctlo_pkg;
   localparam logic [11:0] CTLO_TEST_CTRL_OFF   = 12'h000;
   localparam logic [11:0] CTLO_OVR_STATUS_OFF  = 12'h004;
   localparam logic [11:0] CTLO_TEST_MODE_OFF   = 12'h008;
   localparam int          CTLO_ERR_FREEZE_BIT  = 3;
   localparam int          CTLO_RX_DIS_BIT      = 2;
   localparam int          CTLO_TX_DIS_BIT      = 1;
   localparam int          CTLO_LOOP_BIT        = 0;
   localparam int          CTLO_MBOX_NUM        = 4;
   localparam logic [3:0]  CTLO_TEST_CTRL_RST   = 4'h0;
   localparam logic [3:0]  CTLO_OVR_STATUS_RST  = 4'h0;
   localparam logic        CTLO_TEST_MODE_RST   = 1'b0;
   localparam logic        CTLO_RECESSIVE       = 1'b1;
   localparam logic [8:0]  CTLO_ERR_CNT_RST     = 9'h000;
   typedef struct packed {
      logic [3:0] test_ctrl;
      logic [3:0] ovr_flags;
      logic       test_mode;
      logic [8:0] tx_err_cnt;
      logic [8:0] rx_err_cnt;
      logic [1:0] rx_sync;
      logic [31:0] prdata;
   } ctlo_state_t;
endpackage

// file: bench/ctlo_bus_model.sv
// can bus model: wired-and line seen by the transmit and receive pins
`timescale 1ns/10ps
module ctlo_bus_model (
   // pins of the block
   input  wire logic tx_line,
   output logic      rx_line,
   // another node pulling the bus dominant
   input  wire logic other_dom
);
   // dominant (0) from any node wins, otherwise the bus rests recessive
   assign rx_line = tx_line & ~other_dom;
endmodule // ctlo_bus_model

// file: bench/can_test_loop_and_overrun_status_tb_top.sv
// testbench for the test-loop and overrun status block
`timescale 1ns/10ps
module can_test_loop_and_overrun_status_tb_top;
   import ctlo_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        core_tx_bit, core_rx_bit, tec_inc, tec_dec, rec_inc, rec_dec;
   logic        can_receive_line, can_transmit_line, dom;
   logic [8:0]  transmit_error_counter, receive_error_counter;
   logic [3:0]  mbox_rx_event, receive_pending_flags, remote_frame_pending_flags;
   int          errors, compares;
   ctlo_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .core_tx_bit, .core_rx_bit, .tec_inc,
      .tec_dec, .rec_inc, .rec_dec, .transmit_error_counter,
      .receive_error_counter, .mbox_rx_event, .receive_pending_flags,
      .remote_frame_pending_flags, .can_receive_line, .can_transmit_line);
   ctlo_bus_model bus (.tx_line(can_transmit_line), .rx_line(can_receive_line),
      .other_dom(dom));
   // ****************
   // shared tasks
   // ****************
   task automatic summarize;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // apb transfer; read data and error taken at the pready edge only
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin errors++; summarize(); end
      rd = prdata;
      slv = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // set core stream and bus, let the 2-flop sync settle, then look
   task automatic pin(input logic t, input logic b, input logic et, input logic er);
      @(posedge pclk);
      core_tx_bit <= t; dom <= b;
      repeat (3) @(posedge pclk);
      #1 chk("tx pin", 32'(et), 32'(can_transmit_line));
      chk("core rx", 32'(er), 32'(core_rx_bit));
   endtask
   // one-cycle count request pulse to both counters, then compare
   task automatic pulse(input logic i, input logic d, input logic [8:0] e);
      @(posedge pclk);
      tec_inc <= i; rec_inc <= i; tec_dec <= d; rec_dec <= d;
      @(posedge pclk);
      tec_inc <= 0; rec_inc <= 0; tec_dec <= 0; rec_dec <= 0;
      @(posedge pclk);
      #1 chk("tec", 32'(e), 32'(transmit_error_counter));
      chk("rec", 32'(e), 32'(receive_error_counter));
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      apb(0, CTLO_TEST_CTRL_OFF, 0); chk("ctrl", 0, rd);
      apb(0, CTLO_OVR_STATUS_OFF, 0); chk("ovr", 0, rd);
      apb(0, 12'h0fc, 0); chk("slverr", 1, 32'(slv));
   endtask
   // all test bits set but test mode off: nothing gated
   task automatic t_normal;
      apb(1, CTLO_TEST_CTRL_OFF, 32'hffffffff);
      apb(0, CTLO_TEST_CTRL_OFF, 0); chk("ctrl", 32'h0000000f, rd);
      pin(0, 1, 0, 0);
      pulse(1, 0, 9'h001);
   endtask
   task automatic t_test;
      apb(1, CTLO_TEST_MODE_OFF, 32'h00000001);
      pin(0, 0, 1, 0);
      pin(1, 1, 1, 1);
      pulse(1, 0, 9'h001);
      apb(1, CTLO_TEST_CTRL_OFF, 32'h00000006);
      pin(0, 1, 1, 1);
      pulse(0, 1, 9'h000);
      apb(1, CTLO_TEST_CTRL_OFF, 32'h00000000);
      pin(1, 1, 1, 0);
   endtask
   task automatic t_overrun;
      @(posedge pclk);
      receive_pending_flags <= 4'h5; remote_frame_pending_flags <= 4'h2;
      mbox_rx_event <= 4'hf;
      @(posedge pclk);
      mbox_rx_event <= 4'h0;
      apb(0, CTLO_OVR_STATUS_OFF, 0); chk("ovr set", 32'h00000007, rd);
      apb(1, CTLO_OVR_STATUS_OFF, 32'h00000000);
      apb(0, CTLO_OVR_STATUS_OFF, 0); chk("ovr w0", 32'h00000007, rd);
      apb(1, CTLO_OVR_STATUS_OFF, 32'hffffff05);
      apb(0, CTLO_OVR_STATUS_OFF, 0); chk("ovr w1c", 32'h00000002, rd);
   endtask
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   // main sequence; every input valued at time zero
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      core_tx_bit = 1; dom = 0; mbox_rx_event = 0; receive_pending_flags = 0;
      remote_frame_pending_flags = 0; tec_inc = 0; tec_dec = 0; rec_inc = 0;
      rec_dec = 0; errors = 0; compares = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_normal();
      t_test();
      t_overrun();
      summarize();
   end
endmodule // can_test_loop_and_overrun_status_tb_top
